//--- verilog/bfmdsr_pkg.sv
// Operation
// - Every 16-bit frame carries odd parity over all sixteen bits.
// - Power-on reset loads defaults: masks zero, stop-on-fail one.
// - First mask register bit set disables its rail, boot, temperature or gate fault.
// - Second mask register bit set disables its regulator, supply, logic or drain fault.
// - First diagnostic register reports rail-three faults and four gate undervoltages.
// - Second diagnostic register reports regulator faults and four drain overvoltages.
// - Third diagnostic register reports supply, bootstrap, overcurrent and open load.
// - With strobe high, two control bits select the diagnostic pin source.
// - Bootstrap-manager-off bit set disables the bootstrap charging manager.
// - Stop-on-fail set stops the bridge on a fault other than temperature warning or watchdog timeout; clear only reports.
// - Four control bits drive both gates of phases A and B.
// - Status word returns summary flags; roll-up and power-on flags read one after reset.
// - Supply, regulator, rail-three and load summaries follow their diagnostic bits.
// - Bootstrap, gate-source and drain-source summaries follow their diagnostic bits.
package bfmdsr_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned ADDR_MSB   = 15;
  localparam int unsigned ADDR_LSB   = 12;
  localparam int unsigned WR_BIT     = 11;
  localparam int unsigned PAR_BIT    = 0;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_MASK0 = 4'ha;
  localparam logic [3:0] ADDR_MASK1 = 4'hb;
  localparam logic [3:0] ADDR_DIAG0 = 4'hc;
  localparam logic [3:0] ADDR_DIAG1 = 4'hd;
  localparam logic [3:0] ADDR_DIAG2 = 4'he;
  localparam logic [3:0] ADDR_CTRL  = 4'hf;

  // ----------------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] MASK_WBITS  = 16'h079e;
  localparam logic [15:0] CTRL_WBITS  = 16'h079e;
  localparam logic [15:0] MASK_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_RESET  = 16'h0080;
  localparam logic [15:0] ZERO16      = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions shared by mask, diagnostic and control registers
  // ----------------------------------------------------------------------
  localparam int unsigned F_HI_OVER   = 10;
  localparam int unsigned F_HI_UNDER  = 9;
  localparam int unsigned F_RANGE     = 8;
  localparam int unsigned F_WARN      = 7;
  localparam int unsigned F_GATE_MSB  = 4;
  localparam int unsigned F_GATE_LSB  = 1;
  localparam int unsigned F_BOOT_B    = 7;
  localparam int unsigned F_BOOT_A    = 6;
  localparam int unsigned F_OC_B      = 3;
  localparam int unsigned F_OC_A      = 2;
  localparam int unsigned F_OPEN_LOAD = 1;
  localparam int unsigned F_SEL_MSB   = 10;
  localparam int unsigned F_SEL_LSB   = 9;
  localparam int unsigned F_BOOT_OFF  = 8;
  localparam int unsigned F_STOP_FAIL = 7;

  // ----------------------------------------------------------------------
  // Status word positions
  // ----------------------------------------------------------------------
  localparam int unsigned S_ANY  = 15;
  localparam int unsigned S_POR  = 14;
  localparam int unsigned S_SERR = 13;
  localparam int unsigned S_OT   = 11;
  localparam int unsigned S_TW   = 10;
  localparam int unsigned S_VS   = 9;
  localparam int unsigned S_VLO  = 8;
  localparam int unsigned S_ETO  = 7;
  localparam int unsigned S_VR   = 6;
  localparam int unsigned S_V3   = 5;
  localparam int unsigned S_LDF  = 4;
  localparam int unsigned S_BSU  = 3;
  localparam int unsigned S_GSU  = 2;
  localparam int unsigned S_DSO  = 1;

  // ----------------------------------------------------------------------
  // Diagnostic pin select codes and timing
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_FAULT_LOW,
    SEL_PULSE_FAULT,
    SEL_TEMPERATURE,
    SEL_SENSE_AMP
  } bfmdsr_sel_t;

  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned PULSE_HALF_NS   = 1000;
  localparam int unsigned PULSE_HALF_CYC  = (PULSE_HALF_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam logic [7:0]  PULSE_LAST      = 8'(PULSE_HALF_CYC - 1);

endpackage

//--- verilog/bfmdsr_frame_port.sv
`timescale 1ns/100ps
module bfmdsr_frame_port (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Serial pins
  input  wire logic        strobe_n_i,
  input  wire logic        sclk_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  // Frame side
  input  wire logic [15:0] tx_word_i,
  output logic [15:0]      rx_word_o,
  output logic             frame_done_o,
  output logic             frame_ok_o
);

  logic        sclk_q;
  logic        strobe_q;
  logic [15:0] tx_shift;
  logic [4:0]  bit_count;
  logic        next_sdo;
  logic [15:0] next_rx;
  logic [15:0] next_tx;
  logic [4:0]  next_count;
  logic        next_done;
  logic        next_ok;

  localparam int unsigned FRAME_BITS_W = bfmdsr_pkg::FRAME_BITS;

  // ----------------------------------------------------------------------
  // Shifter: sample on rising clock, present on falling clock
  // ----------------------------------------------------------------------
  always_comb begin
    next_sdo   = sdo_o;
    next_rx    = rx_word_o;
    next_tx    = tx_shift;
    next_count = bit_count;
    next_done  = 1'b0;
    next_ok    = frame_ok_o;
    if (strobe_q && !strobe_n_i) begin
      next_tx    = tx_word_i;
      next_sdo   = tx_word_i[15];
      next_count = 5'h00;
    end else if (!strobe_n_i) begin
      if (!sclk_q && sclk_i) begin
        next_rx = {rx_word_o[14:0], sdi_i};
        if (bit_count != 5'h1f) begin
          next_count = bit_count + 5'h01;
        end
      end else if (sclk_q && !sclk_i) begin
        next_tx  = {tx_shift[14:0], 1'b0};
        next_sdo = tx_shift[14];
      end
    end else begin
      next_sdo = 1'b0;
      if (!strobe_q) begin
        // Over- or under-length frames are flagged, never executed.
        next_done = 1'b1;
        next_ok   = (bit_count == 5'(FRAME_BITS_W));
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_q       <= 1'b0;
      strobe_q     <= 1'b1;
      sdo_o        <= 1'b0;
      rx_word_o    <= 16'h0000;
      tx_shift     <= 16'h0000;
      bit_count    <= 5'h00;
      frame_done_o <= 1'b0;
      frame_ok_o   <= 1'b0;
    end else begin
      sclk_q       <= sclk_i;
      strobe_q     <= strobe_n_i;
      sdo_o        <= next_sdo;
      rx_word_o    <= next_rx;
      tx_shift     <= next_tx;
      bit_count    <= next_count;
      frame_done_o <= next_done;
      frame_ok_o   <= next_ok;
    end
  end

endmodule

//--- verilog/bfmdsr_regs.sv
`timescale 1ns/100ps
module bfmdsr_regs (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Serial port
  input  wire logic       strobe_n_i,
  input  wire logic       sclk_i,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  // Fault detector inputs, high means present
  input  wire logic       rail3_over_i,
  input  wire logic       rail3_under_i,
  input  wire logic       regulator_over_i,
  input  wire logic       regulator_under_i,
  input  wire logic       supply_over_i,
  input  wire logic       supply_under_i,
  input  wire logic [3:0] gate_under_i,
  input  wire logic [3:0] drain_over_i,
  input  wire logic [1:0] boot_under_i,
  input  wire logic [1:0] overcurrent_i,
  input  wire logic       open_load_i,
  input  wire logic       temp_warning_i,
  input  wire logic       over_temp_i,
  input  wire logic       logic_overvoltage_i,
  input  wire logic       enable_watchdog_timeout_i,
  // Diagnostic pin sources
  input  wire logic       temp_signal_i,
  input  wire logic       sense_amp_i,
  // Bridge side
  output logic [3:0]      gate_cmd_o,
  output logic            bridge_stop_o,
  output logic            bootstrap_mgr_off_o,
  output logic            diag_pin_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] with_parity(input logic [15:0] w);
    logic [15:0] r;
    r    = {w[15:1], 1'b0};
    r[0] = ~(^r[15:1]);
    return r;
  endfunction

  function automatic logic [15:0] merge_write(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [15:0] wbits);
    return (old_v & ~wbits) | (new_v & wbits);
  endfunction

  // ----------------------------------------------------------------------
  // Serial frame port
  // ----------------------------------------------------------------------
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic        frame_done;
  logic        frame_ok;

  bfmdsr_frame_port u_port (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .strobe_n_i   (strobe_n_i),
    .sclk_i       (sclk_i),
    .sdi_i        (sdi_i),
    .sdo_o        (sdo_o),
    .tx_word_i    (tx_word),
    .rx_word_o    (rx_word),
    .frame_done_o (frame_done),
    .frame_ok_o   (frame_ok)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [15:0] fault_mask_rails_gate_under;
  logic [15:0] fault_mask_supply_drain_over;
  logic [15:0] bridge_control;
  logic [15:0] diag_rail_gate_under;
  logic [15:0] diag_regulator_drain_over;
  logic [15:0] diag_supply_boot_load;
  logic        por_flag;
  logic        frame_error_flag;
  logic        reply_is_reg;
  logic [3:0]  reply_addr;
  logic [7:0]  pulse_count;
  logic        pulse_level;

  logic [15:0] next_mask0;
  logic [15:0] next_mask1;
  logic [15:0] next_ctrl;
  logic [15:0] next_diag0;
  logic [15:0] next_diag1;
  logic [15:0] next_diag2;
  logic        next_por;
  logic        next_serr;
  logic        next_reply_is_reg;
  logic [3:0]  next_reply_addr;
  logic [7:0]  next_pulse_count;
  logic        next_pulse_level;
  logic [3:0]  next_gate_cmd;
  logic        next_stop;
  logic        next_diag_pin;

  // ----------------------------------------------------------------------
  // Fault qualification
  // ----------------------------------------------------------------------
  logic [15:0] m0;
  logic [15:0] m1;
  logic [15:0] live0;
  logic [15:0] live1;
  logic [15:0] live2;
  logic [15:0] en0;
  logic [15:0] en1;
  logic [15:0] en2;

  assign m0 = fault_mask_rails_gate_under;
  assign m1 = fault_mask_supply_drain_over;

  // A mask bit set removes the fault from its diagnostic bit.
  assign en0 = {5'h00, ~m0[10], ~m0[9], 4'h0, ~m0[4:1], 1'b0};
  assign en1 = {5'h00, ~m1[10], ~m1[9], 4'h0, ~m1[4:1], 1'b0};
  assign en2 = {5'h00, ~m1[8], ~m1[8], 1'b0, ~m0[8], ~m0[8], 2'b00,
                3'b111, 1'b0};

  assign live0 = {5'h00, rail3_over_i, rail3_under_i, 4'h0, gate_under_i, 1'b0}
                 & en0;
  assign live1 = {5'h00, regulator_over_i, regulator_under_i, 4'h0, drain_over_i,
                  1'b0} & en1;
  assign live2 = {5'h00, supply_over_i, supply_under_i, 1'b0, boot_under_i, 2'b00,
                  overcurrent_i, open_load_i, 1'b0} & en2;

  localparam int unsigned F_WARN_I = bfmdsr_pkg::F_WARN;

  logic warn_live;
  logic logic_ov_live;
  assign warn_live     = temp_warning_i & ~m0[F_WARN_I];
  assign logic_ov_live = logic_overvoltage_i & ~m1[F_WARN_I];

  // ----------------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------------
  logic [15:0] status_word;
  logic        any_summary;

  always_comb begin
    status_word = 16'h0000;
    status_word[bfmdsr_pkg::S_POR]  = por_flag;
    status_word[bfmdsr_pkg::S_SERR] = frame_error_flag;
    status_word[bfmdsr_pkg::S_OT]   = over_temp_i;
    status_word[bfmdsr_pkg::S_TW]   = warn_live;
    status_word[bfmdsr_pkg::S_VLO]  = logic_ov_live;
    status_word[bfmdsr_pkg::S_ETO]  = enable_watchdog_timeout_i;
    status_word[bfmdsr_pkg::S_VS]   = diag_supply_boot_load[10]
                                      | diag_supply_boot_load[9];
    status_word[bfmdsr_pkg::S_VR]   = diag_regulator_drain_over[10]
                                      | diag_regulator_drain_over[9];
    status_word[bfmdsr_pkg::S_V3]   = diag_rail_gate_under[10]
                                      | diag_rail_gate_under[9];
    status_word[bfmdsr_pkg::S_LDF]  = |diag_supply_boot_load[3:1];
    status_word[bfmdsr_pkg::S_BSU]  = |diag_supply_boot_load[7:6];
    status_word[bfmdsr_pkg::S_GSU]  = |diag_rail_gate_under[4:1];
    status_word[bfmdsr_pkg::S_DSO]  = |diag_regulator_drain_over[4:1];
    // The roll-up flag also covers power-on, so it reads one after reset.
    status_word[bfmdsr_pkg::S_ANY]  = |status_word[14:1];
  end

  assign any_summary = |{diag_rail_gate_under, diag_regulator_drain_over,
                         diag_supply_boot_load, over_temp_i, logic_ov_live};

  // ----------------------------------------------------------------------
  // Reply selection for the next frame
  // ----------------------------------------------------------------------
  always_comb begin
    tx_word = status_word;
    if (reply_is_reg) begin
      case (reply_addr)
        bfmdsr_pkg::ADDR_MASK0: tx_word = {reply_addr, 1'b0, m0[10:0]};
        bfmdsr_pkg::ADDR_MASK1: tx_word = {reply_addr, 1'b0, m1[10:0]};
        bfmdsr_pkg::ADDR_DIAG0: tx_word = {reply_addr, 1'b0, diag_rail_gate_under[10:0]};
        bfmdsr_pkg::ADDR_DIAG1: tx_word = {reply_addr, 1'b0,
                                           diag_regulator_drain_over[10:0]};
        bfmdsr_pkg::ADDR_DIAG2: tx_word = {reply_addr, 1'b0, diag_supply_boot_load[10:0]};
        bfmdsr_pkg::ADDR_CTRL:  tx_word = {reply_addr, 1'b0, bridge_control[10:0]};
        default:                tx_word = status_word;
      endcase
    end
    tx_word = with_parity(tx_word);
  end

  // ----------------------------------------------------------------------
  // Register file next state
  // ----------------------------------------------------------------------
  logic        frame_good;
  logic        frame_write;
  logic [3:0]  frame_addr;
  logic [15:0] clr0;
  logic [15:0] clr1;
  logic [15:0] clr2;
  logic        clr_status;

  assign frame_addr  = rx_word[bfmdsr_pkg::ADDR_MSB:bfmdsr_pkg::ADDR_LSB];
  assign frame_write = rx_word[bfmdsr_pkg::WR_BIT];
  assign frame_good  = frame_done && frame_ok && (^rx_word);

  // A completed reply clears what it carried; a fault still present sets again.
  assign clr_status = frame_done && !reply_is_reg;
  assign clr0 = (frame_done && reply_is_reg && reply_addr == bfmdsr_pkg::ADDR_DIAG0)
                ? 16'hffff : 16'h0000;
  assign clr1 = (frame_done && reply_is_reg && reply_addr == bfmdsr_pkg::ADDR_DIAG1)
                ? 16'hffff : 16'h0000;
  assign clr2 = (frame_done && reply_is_reg && reply_addr == bfmdsr_pkg::ADDR_DIAG2)
                ? 16'hffff : 16'h0000;

  always_comb begin
    next_mask0        = fault_mask_rails_gate_under;
    next_mask1        = fault_mask_supply_drain_over;
    next_ctrl         = bridge_control;
    next_reply_is_reg = reply_is_reg;
    next_reply_addr   = reply_addr;
    // Set wins over clear for every latched flag.
    next_diag0 = (live0 | (diag_rail_gate_under & ~clr0)) & en0;
    next_diag1 = (live1 | (diag_regulator_drain_over & ~clr1)) & en1;
    next_diag2 = (live2 | (diag_supply_boot_load & ~clr2)) & en2;
    next_por   = por_flag & ~clr_status;
    next_serr  = frame_error_flag & ~clr_status;
    if (frame_done && !frame_good) begin
      next_serr         = 1'b1;
      next_reply_is_reg = 1'b0;
    end else if (frame_good) begin
      if (frame_write) begin
        // Diagnostic addresses have no writable bits, so a write is dropped.
        case (frame_addr)
          bfmdsr_pkg::ADDR_MASK0: next_mask0 = merge_write(m0, rx_word,
                                                           bfmdsr_pkg::MASK_WBITS);
          bfmdsr_pkg::ADDR_MASK1: next_mask1 = merge_write(m1, rx_word,
                                                           bfmdsr_pkg::MASK_WBITS);
          bfmdsr_pkg::ADDR_CTRL:  next_ctrl  = merge_write(bridge_control, rx_word,
                                                           bfmdsr_pkg::CTRL_WBITS);
          default:                next_ctrl  = bridge_control;
        endcase
        next_reply_is_reg = 1'b0;
      end else begin
        next_reply_is_reg = (frame_addr >= bfmdsr_pkg::ADDR_MASK0);
        next_reply_addr   = frame_addr;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_mask_rails_gate_under  <= bfmdsr_pkg::MASK_RESET;
      fault_mask_supply_drain_over <= bfmdsr_pkg::MASK_RESET;
      bridge_control               <= bfmdsr_pkg::CTRL_RESET;
      diag_rail_gate_under         <= bfmdsr_pkg::ZERO16;
      diag_regulator_drain_over    <= bfmdsr_pkg::ZERO16;
      diag_supply_boot_load        <= bfmdsr_pkg::ZERO16;
      por_flag                     <= 1'b1;
      frame_error_flag             <= 1'b0;
      reply_is_reg                 <= 1'b0;
      reply_addr                   <= 4'h0;
    end else begin
      fault_mask_rails_gate_under  <= next_mask0;
      fault_mask_supply_drain_over <= next_mask1;
      bridge_control               <= next_ctrl;
      diag_rail_gate_under         <= next_diag0;
      diag_regulator_drain_over    <= next_diag1;
      diag_supply_boot_load        <= next_diag2;
      por_flag                     <= next_por;
      frame_error_flag             <= next_serr;
      reply_is_reg                 <= next_reply_is_reg;
      reply_addr                   <= next_reply_addr;
    end
  end

  // ----------------------------------------------------------------------
  // Bridge outputs and diagnostic pin
  // ----------------------------------------------------------------------
  bfmdsr_pkg::bfmdsr_sel_t pin_sel;
  assign pin_sel = bfmdsr_pkg::bfmdsr_sel_t'(bridge_control[10:9]);

  always_comb begin
    next_stop        = bridge_control[bfmdsr_pkg::F_STOP_FAIL] & any_summary;
    next_gate_cmd    = next_stop ? 4'h0 : bridge_control[4:1];
    next_pulse_count = pulse_count;
    next_pulse_level = 1'b0;
    if (any_summary) begin
      next_pulse_level = pulse_level;
      if (pulse_count == bfmdsr_pkg::PULSE_LAST) begin
        next_pulse_count = 8'h00;
        next_pulse_level = ~pulse_level;
      end else begin
        next_pulse_count = pulse_count + 8'h01;
      end
    end else begin
      next_pulse_count = 8'h00;
    end
    // During a frame the pin always shows the low-true fault flag.
    next_diag_pin = ~any_summary;
    if (strobe_n_i) begin
      case (pin_sel)
        bfmdsr_pkg::SEL_FAULT_LOW:   next_diag_pin = ~any_summary;
        bfmdsr_pkg::SEL_PULSE_FAULT: next_diag_pin = pulse_level;
        bfmdsr_pkg::SEL_TEMPERATURE: next_diag_pin = temp_signal_i;
        bfmdsr_pkg::SEL_SENSE_AMP:   next_diag_pin = sense_amp_i;
        default:                     next_diag_pin = ~any_summary;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gate_cmd_o    <= 4'h0;
      bridge_stop_o <= 1'b0;
      diag_pin_o    <= 1'b1;
      pulse_count   <= 8'h00;
      pulse_level   <= 1'b0;
    end else begin
      gate_cmd_o    <= next_gate_cmd;
      bridge_stop_o <= next_stop;
      diag_pin_o    <= next_diag_pin;
      pulse_count   <= next_pulse_count;
      pulse_level   <= next_pulse_level;
    end
  end

  // The control bit itself is a flip-flop, so it goes straight out.
  assign bootstrap_mgr_off_o = bridge_control[bfmdsr_pkg::F_BOOT_OFF];

endmodule

//--- verif/bfmdsr_checker.sv
`timescale 1ns/100ps
module bfmdsr_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_i,
  // Watched ports
  input wire logic       strobe_n_i,
  input wire logic       sclk_i,
  input wire logic       sdo_o,
  input wire logic [3:0] gate_cmd_o,
  input wire logic       bridge_stop_o,
  input wire logic       bootstrap_mgr_off_o
);
  logic       sclk_q, strb_q;
  logic [3:0] ev_sr, stop_sr;
  // Edge history lets a late or orphan change of sdo be caught without a model.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {sclk_q, strb_q, ev_sr, stop_sr} <= 10'h100;
    end else begin
      {sclk_q, strb_q} <= {sclk_i, strobe_n_i};
      ev_sr <= {ev_sr[2:0], (sclk_q & ~sclk_i) | (strb_q ^ strobe_n_i)};
      stop_sr <= {stop_sr[2:0], bridge_stop_o};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_gate_after_frame: assert property (
    $changed(gate_cmd_o) && !bridge_stop_o && stop_sr == 4'h0
    |-> $past(strobe_n_i, 3) && !$past(strobe_n_i, 4)) else $error("gate timing");
  a_mgr_after_frame: assert property ($changed(bootstrap_mgr_off_o)
    |-> $past(strobe_n_i, 2) && !$past(strobe_n_i, 3)) else $error("mgr timing");
  a_sdo_idle_low: assert property (
    strobe_n_i && $past(strobe_n_i) && $past(strobe_n_i, 2) |-> !sdo_o) else $error("sdo idle");
  a_sdo_shift_cause: assert property (
    $changed(sdo_o) |-> ev_sr != 4'h0) else $error("sdo orphan change");
  a_stop_gates_off: assert property (
    bridge_stop_o && $past(bridge_stop_o) |-> gate_cmd_o == 4'h0) else $error("stop gates");
  a_mgr_stable_frame: assert property (
    (!strobe_n_i)[*4] |-> $stable(bootstrap_mgr_off_o)) else $error("mgr in frame");
  a_gate_stable_frame: assert property (
    (!strobe_n_i)[*4] ##0 (stop_sr == 4'h0 && !bridge_stop_o) |-> $stable(gate_cmd_o))
    else $error("gate in frame");
  a_sdo_start_low: assert property ($fell(strobe_n_i) |-> !sdo_o)
    else $error("sdo start");
endmodule

//--- verif/bfmdsr_host.sv
`timescale 1ns/100ps
module bfmdsr_host (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  input  wire logic sdo_i,
  output logic      strobe_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  initial {strobe_n_o, sclk_o, sdi_o} = 3'h4;
  // Half periods under two clocks would race the sampler, so hold stays at four or more.
  task automatic xfer(input logic [15:0] word, input int hold, output logic [15:0] reply);
    @(posedge clk_i) #1 strobe_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_o = word[i];
      repeat (hold) @(posedge clk_i);
      #1 sclk_o = 1'b1;
      reply[i] = sdo_i;
      repeat (hold) @(posedge clk_i);
      #1 sclk_o = 1'b0;
    end
    repeat (hold) @(posedge clk_i);
    #1 strobe_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (5) @(posedge clk_i);
    #1;
  endtask
endmodule

//--- verif/bfmdsr_regs_tb.sv
`timescale 1ns/100ps
module bfmdsr_regs_tb;
  logic        clk_i = 1'b0, reset_i = 1'b1, ts = 1'b0, sa = 1'b0;
  logic        strobe_n, sclk, sdi, sdo, stop, mgr, dpin;
  logic [22:0] flt = 23'h00_0000;
  logic [3:0]  gate, g;
  logic [15:0] r;
  logic [11:0] f;
  integer      seed = 32'h0000_9b1a;
  int          n_errors = 0, checks = 0;
  always #2.5 clk_i = ~clk_i;
  `define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
  bfmdsr_regs i_bfmdsr_regs (.clk_i(clk_i), .reset_i(reset_i), .strobe_n_i(strobe_n),
    .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .rail3_over_i(flt[0]), .rail3_under_i(flt[1]),
    .regulator_over_i(flt[2]), .regulator_under_i(flt[3]), .supply_over_i(flt[4]),
    .supply_under_i(flt[5]), .gate_under_i(flt[9:6]), .drain_over_i(flt[13:10]),
    .boot_under_i(flt[15:14]), .overcurrent_i(flt[17:16]), .open_load_i(flt[18]),
    .temp_warning_i(flt[19]), .over_temp_i(flt[20]), .logic_overvoltage_i(flt[21]),
    .enable_watchdog_timeout_i(flt[22]), .temp_signal_i(ts), .sense_amp_i(sa),
    .gate_cmd_o(gate), .bridge_stop_o(stop), .bootstrap_mgr_off_o(mgr), .diag_pin_o(dpin));
  bfmdsr_host i_bfmdsr_host (.clk_i(clk_i), .sdo_i(sdo), .strobe_n_o(strobe_n),
    .sclk_o(sclk), .sdi_o(sdi));
  function automatic logic [15:0] par(input logic [15:0] x);
    return {x[15:1], ~^x[15:1]};
  endfunction
  function automatic logic [15:0] roll(input logic [11:0] x);
    return {11'h000, |x[11:10], |x[9:8], |x[3:0], |x[7:4], 1'b0};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic xf(input logic [15:0] w);
    i_bfmdsr_host.xfer(w, 4, r);
  endtask
  task automatic ctrl(input logic [1:0] s, input logic m, input logic e, input logic [3:0] c);
    xf(par({4'hf, 1'b1, s, m, e, 2'b00, c, 1'b0}));
  endtask
  task automatic pulse(input int b);
    flt[b] = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 flt[b] = 1'b0;
  endtask
  initial begin
    #100000 n_errors++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    `CHK({sdo, gate, stop, mgr, dpin}, 8'h01)
    #1 reset_i = 1'b0;
    i_bfmdsr_host.xfer(par(16'hf000), 7, r);
    `CHK(r, par(16'hc000))
    g = 4'($random(seed));
    ctrl(2'd0, 1'b1, 1'b0, g);
    `CHK(r, par(16'hf080))
    xf(par(16'h0000));
    `CHK(r, par(16'h0000))
    `CHK({gate, mgr}, {g, 1'b1})
    for (int s = 0; s < 4; s++) begin
      ctrl(2'(s), 1'b0, 1'b0, 4'h0);
      {ts, sa} = 2'($random(seed));
      @(posedge clk_i);
      #1 `CHK(dpin, s == 0 ? 1'b1 : s == 1 ? 1'b0 : s == 2 ? ts : sa)
    end
    ctrl(2'd0, 1'b0, 1'b1, 4'hf);
    pulse(20);
    `CHK({stop, gate}, 5'h10)
    ctrl(2'd0, 1'b0, 1'b0, 4'hf);
    `CHK({stop, gate}, 5'h0f)
    pulse(0);
    xf(par(16'hc000));
    xf(par(16'hac00));
    `CHK(r, par(16'hc400))
    pulse(0);
    xf(par(16'hc000));
    xf(par(16'h0000));
    `CHK(r, par(16'hc000))
    flt[5] = 1'b1;
    flt[20] = 1'b1;
    xf(16'hf000);
    `CHK(stop, 1'b0)
    xf(par(16'h0000));
    `CHK(r, par(16'haa00))
    f = 12'($random(seed));
    flt = {5'h00, f, 6'h00};
    @(posedge clk_i);
    #1 flt = 23'h00_0000;
    xf(par(16'hd000));
    `CHK(r, par(16'h8200 | roll(f)))
    xf(par(16'h0000));
    `CHK(r, par({4'hd, 7'h00, f[7:4], 1'b0}))
    ctrl(2'd1, 1'b0, 1'b0, 4'h0);
    g = {3'h0, dpin};
    repeat (bfmdsr_pkg::PULSE_HALF_CYC) @(posedge clk_i);
    #1 `CHK(dpin, ~g[0])
    xf(par(16'hb81e));
    flt[13:10] = 4'hf;
    @(posedge clk_i);
    #1 flt[13:10] = 4'h0;
    xf(par(16'hd000));
    xf(par(16'h0000));
    `CHK(r, par(16'hd000))
    $display("test sequence done");
    finish_test();
  end
endmodule
bind bfmdsr_regs bfmdsr_checker i_bfmdsr_checker (.clk_i(clk_i), .reset_i(reset_i),
  .strobe_n_i(strobe_n_i), .sclk_i(sclk_i), .sdo_o(sdo_o), .gate_cmd_o(gate_cmd_o),
  .bridge_stop_o(bridge_stop_o), .bootstrap_mgr_off_o(bootstrap_mgr_off_o));
